// File: rtl/ldsmb_slave.sv
/*
  Two-wire slave engine of the lamp dimmer with its register file.
  Assumes a bus master drives the clock pin, open-drain wiring outside,
  and fault flags arriving synchronous to sys_clk from the lamp logic.
*/
`timescale 1ns/100ps
module ldsmb_slave #(
  parameter logic [7:0] PART_ID = 8'h5c,   // arbitrary value
  parameter logic [7:0] PART_REV = 8'h01,  // arbitrary value
  parameter logic [7:0] MAKER_ID = 8'h3a   // arbitrary value
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // interface select strap
  input wire logic iface_select_strap,
  // two-wire pins
  input wire logic shared_clock_pin,
  input wire logic shared_data_in,
  output logic shared_data_out,
  output logic shared_data_oen_n,
  // lamp side
  input wire logic [1:0] fault_flags,
  output logic [4:0] lamp_level,
  output logic [2:0] lamp_off_policy
);

  // ----------------------------------------------------------------
  // link domain: sample data on every clock rise
  // ----------------------------------------------------------------
  logic link_tog_q, link_tog_d;
  logic link_bit_q, link_bit_d;

  always_comb begin
    link_tog_d = ~link_tog_q;
    link_bit_d = shared_data_in;
  end

  always_ff @(posedge shared_clock_pin or negedge resetn) begin
    if (!resetn) begin
      link_tog_q <= 1'b0;
      link_bit_q <= 1'b0;
    end else begin
      link_tog_q <= link_tog_d;
      link_bit_q <= link_bit_d;
    end
  end

  // ----------------------------------------------------------------
  // crossing into sys_clk and line events
  // ----------------------------------------------------------------
  logic [ldsmb_pkg::SYNC_W-1:0] sync_in, sync_out;
  logic scl_s, sda_s, iface_en, tog_s;
  logic scl_prev_q, sda_prev_q, tog_seen_q;
  logic rise_ev, fall_ev, start_ev, stop_ev;

  always_comb begin
    sync_in = '0;
    sync_in[ldsmb_pkg::SY_SCL] = shared_clock_pin;
    sync_in[ldsmb_pkg::SY_SDA] = shared_data_in;
    sync_in[ldsmb_pkg::SY_STRAP] = iface_select_strap;
    sync_in[ldsmb_pkg::SY_TOG] = link_tog_q;
  end

  ldsmb_sync #(
    .WIDTH(ldsmb_pkg::SYNC_W)
  ) u_sync (
    .clk(sys_clk),
    .resetn(resetn),
    .async_in(sync_in),
    .sync_out(sync_out)
  );

  assign scl_s = sync_out[ldsmb_pkg::SY_SCL];
  assign sda_s = sync_out[ldsmb_pkg::SY_SDA];
  assign iface_en = sync_out[ldsmb_pkg::SY_STRAP];
  assign tog_s = sync_out[ldsmb_pkg::SY_TOG];

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      // match the synchroniser reset level, so no false fall follows reset
      scl_prev_q <= 1'b0;
      sda_prev_q <= 1'b0;
      tog_seen_q <= 1'b0;
    end else begin
      scl_prev_q <= scl_s;
      sda_prev_q <= sda_s;
      tog_seen_q <= tog_s;
    end
  end

  // link_bit_q is held since the toggle moved, so safe to read here
  assign rise_ev = tog_s ^ tog_seen_q;
  assign fall_ev = scl_prev_q & ~scl_s;
  assign start_ev = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
  assign stop_ev = scl_s & scl_prev_q & ~sda_prev_q & sda_s;

  // ----------------------------------------------------------------
  // byte engine
  // ----------------------------------------------------------------
  ldsmb_pkg::ldsmb_state_e state_q, state_d;
  logic [3:0] bit_cnt_q, bit_cnt_d;
  logic [7:0] rx_q, rx_d;
  logic [7:0] tx_q, tx_d;
  logic [7:0] cmd_q, cmd_d;
  logic [7:0] data_q, data_d;
  logic cmd_got_q, cmd_got_d;
  logic data_got_q, data_got_d;
  logic mack_q, mack_d;
  logic oen_n_q, oen_n_d;
  logic ptr_we_q, ptr_we_d;
  logic data_we_q, data_we_d;
  logic wr_err;
  logic [7:0] rd_data;

  always_comb begin
    state_d = state_q;
    bit_cnt_d = bit_cnt_q;
    rx_d = rx_q;
    tx_d = tx_q;
    cmd_d = cmd_q;
    data_d = data_q;
    cmd_got_d = cmd_got_q;
    data_got_d = data_got_q;
    mack_d = mack_q;
    oen_n_d = oen_n_q;
    ptr_we_d = 1'b0;
    data_we_d = 1'b0;
    // a byte in flight that was not yet acknowledged; the clock rise
    // that sets up a stop or restart counts one bit and is not an error
    wr_err = ((state_q == ldsmb_pkg::ST_CMD) && (bit_cnt_q > ldsmb_pkg::BIT_ONE) && !cmd_got_q) ||
             ((state_q == ldsmb_pkg::ST_DATA) && (bit_cnt_q > ldsmb_pkg::BIT_ONE) && !data_got_q);
    if (!iface_en) begin
      state_d = ldsmb_pkg::ST_IDLE;
      bit_cnt_d = ldsmb_pkg::BIT_ZERO;
      cmd_got_d = 1'b0;
      data_got_d = 1'b0;
      oen_n_d = 1'b1;
    end else if (start_ev || stop_ev) begin
      if (!wr_err) begin
        ptr_we_d = cmd_got_q;
        data_we_d = data_got_q;
      end
      cmd_got_d = 1'b0;
      data_got_d = 1'b0;
      oen_n_d = 1'b1;
      bit_cnt_d = ldsmb_pkg::BIT_ZERO;
      state_d = start_ev ? ldsmb_pkg::ST_ADDR : ldsmb_pkg::ST_IDLE;
    end else begin
      if (rise_ev) begin
        if (bit_cnt_q != ldsmb_pkg::BIT_END) begin
          bit_cnt_d = bit_cnt_q + ldsmb_pkg::BIT_ONE;
        end
        if (bit_cnt_q < ldsmb_pkg::BIT_ACK) begin
          rx_d = {rx_q[6:0], link_bit_q};
        end
        if (bit_cnt_q == ldsmb_pkg::BIT_ACK) begin
          mack_d = ~link_bit_q;
        end
      end
      if (fall_ev) begin
        case (state_q)
          ldsmb_pkg::ST_ADDR, ldsmb_pkg::ST_CMD, ldsmb_pkg::ST_DATA: begin
            if (bit_cnt_q == ldsmb_pkg::BIT_ACK) begin
              oen_n_d = 1'b0;
              if (state_q == ldsmb_pkg::ST_ADDR && rx_q[7:1] != ldsmb_pkg::SLAVE_ADDR) begin
                oen_n_d = 1'b1;
                state_d = ldsmb_pkg::ST_SKIP;
              end
              if (state_q == ldsmb_pkg::ST_CMD) begin
                cmd_d = rx_q;
                cmd_got_d = 1'b1;
              end
              if (state_q == ldsmb_pkg::ST_DATA) begin
                data_d = rx_q;
                data_got_d = 1'b1;
              end
            end else if (bit_cnt_q == ldsmb_pkg::BIT_END) begin
              oen_n_d = 1'b1;
              bit_cnt_d = ldsmb_pkg::BIT_ZERO;
              if (state_q == ldsmb_pkg::ST_ADDR) begin
                if (rx_q[0]) begin
                  state_d = ldsmb_pkg::ST_TX;
                  oen_n_d = rd_data[7];
                  tx_d = {rd_data[6:0], 1'b1};
                end else begin
                  state_d = ldsmb_pkg::ST_CMD;
                end
              end else if (state_q == ldsmb_pkg::ST_CMD) begin
                state_d = ldsmb_pkg::ST_DATA;
              end else begin
                state_d = ldsmb_pkg::ST_SKIP;
              end
            end
          end
          ldsmb_pkg::ST_TX: begin
            if (bit_cnt_q == ldsmb_pkg::BIT_END) begin
              bit_cnt_d = ldsmb_pkg::BIT_ZERO;
              if (mack_q) begin
                oen_n_d = rd_data[7];
                tx_d = {rd_data[6:0], 1'b1};
              end else begin
                oen_n_d = 1'b1;
                state_d = ldsmb_pkg::ST_SKIP;
              end
            end else if (bit_cnt_q == ldsmb_pkg::BIT_ACK) begin
              oen_n_d = 1'b1;
            end else begin
              oen_n_d = tx_q[7];
              tx_d = {tx_q[6:0], 1'b1};
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= ldsmb_pkg::ST_IDLE;
      bit_cnt_q <= ldsmb_pkg::BIT_ZERO;
      rx_q <= 8'h00;
      tx_q <= 8'hff;
      cmd_q <= 8'h00;
      data_q <= 8'h00;
      cmd_got_q <= 1'b0;
      data_got_q <= 1'b0;
      mack_q <= 1'b0;
      oen_n_q <= 1'b1;
      ptr_we_q <= 1'b0;
      data_we_q <= 1'b0;
    end else begin
      state_q <= state_d;
      bit_cnt_q <= bit_cnt_d;
      rx_q <= rx_d;
      tx_q <= tx_d;
      cmd_q <= cmd_d;
      data_q <= data_d;
      cmd_got_q <= cmd_got_d;
      data_got_q <= data_got_d;
      mack_q <= mack_d;
      oen_n_q <= oen_n_d;
      ptr_we_q <= ptr_we_d;
      data_we_q <= data_we_d;
    end
  end

  assign shared_data_out = 1'b0;
  assign shared_data_oen_n = oen_n_q;

  // ----------------------------------------------------------------
  // registers; no shutdown input gates the bus
  // ----------------------------------------------------------------
  ldsmb_regs #(
    .PART_ID(PART_ID),
    .PART_REV(PART_REV),
    .MAKER_ID(MAKER_ID)
  ) u_regs (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .ptr_we(ptr_we_q),
    .data_we(data_we_q),
    .cmd_in(cmd_q),
    .data_in(data_q),
    .fault_flags(fault_flags),
    .lamp_level(lamp_level),
    .lamp_off_policy(lamp_off_policy),
    .rd_data(rd_data)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_strap_release: assert property (@(posedge sys_clk) disable iff (!resetn)
    !iface_en |=> (oen_n_q && state_q == ldsmb_pkg::ST_IDLE))
    else $error("bus active without strap");

  a_start_addr: assert property (@(posedge sys_clk) disable iff (!resetn)
    (iface_en && start_ev) |=> (state_q == ldsmb_pkg::ST_ADDR && bit_cnt_q == ldsmb_pkg::BIT_ZERO))
    else $error("start not taken");

  a_stop_idle: assert property (@(posedge sys_clk) disable iff (!resetn)
    (iface_en && stop_ev) |=> (state_q == ldsmb_pkg::ST_IDLE && oen_n_q))
    else $error("stop not taken");

  a_drive_clock_low: assert property (@(posedge sys_clk) disable iff (!resetn)
    (oen_n_q != $past(oen_n_q)) |-> !$past(scl_s) || $past(start_ev || stop_ev || !iface_en))
    else $error("data drive moved while clock high");

  a_bit_count: assert property (@(posedge sys_clk) disable iff (!resetn)
    (iface_en && rise_ev && !start_ev && !stop_ev && bit_cnt_q < ldsmb_pkg::BIT_END) |=>
    (bit_cnt_q == $past(bit_cnt_q) + ldsmb_pkg::BIT_ONE))
    else $error("bit count off");

  a_addr_ack: assert property (@(posedge sys_clk) disable iff (!resetn)
    (iface_en && !start_ev && !stop_ev && fall_ev && state_q == ldsmb_pkg::ST_ADDR &&
     bit_cnt_q == ldsmb_pkg::BIT_ACK && rx_q[7:1] == ldsmb_pkg::SLAVE_ADDR) |=> !oen_n_q)
    else $error("own address not acknowledged");

  a_foreign_nack: assert property (@(posedge sys_clk) disable iff (!resetn)
    (iface_en && !start_ev && !stop_ev && fall_ev && state_q == ldsmb_pkg::ST_ADDR &&
     bit_cnt_q == ldsmb_pkg::BIT_ACK && rx_q[7:1] != ldsmb_pkg::SLAVE_ADDR) |=>
    (oen_n_q && state_q == ldsmb_pkg::ST_SKIP))
    else $error("foreign address acknowledged");

  a_error_discard: assert property (@(posedge sys_clk) disable iff (!resetn)
    (iface_en && wr_err && (start_ev || stop_ev)) |=> (!ptr_we_q && !data_we_q))
    else $error("broken write committed");

  a_commit_at_end: assert property (@(posedge sys_clk) disable iff (!resetn)
    (ptr_we_q || data_we_q) |-> $past(start_ev || stop_ev))
    else $error("commit outside stop or restart");

  a_data_needs_cmd: assert property (@(posedge sys_clk) disable iff (!resetn)
    data_we_q |-> ptr_we_q)
    else $error("data committed without command");

  a_tx_first_bit: assert property (@(posedge sys_clk) disable iff (!resetn)
    (state_q == ldsmb_pkg::ST_ADDR && $past(state_q) == ldsmb_pkg::ST_ADDR) ##1
    (state_q == ldsmb_pkg::ST_TX) |-> (oen_n_q == $past(rd_data[7])))
    else $error("read did not present register msb");

endmodule : ldsmb_slave

// File: rtl/ldsmb_pkg.sv
/*
  Shared constants and types of the lamp dimmer two-wire slave.
  Assumes nothing of its surroundings; used by ldsmb_slave and ldsmb_regs, not by ldsmb_sync.
*/
package ldsmb_pkg;

  // ----------------------------------------------------------------
  // bus addressing and byte framing
  // ----------------------------------------------------------------
  localparam logic [6:0] SLAVE_ADDR = 7'h2d;
  localparam logic [3:0] BIT_ZERO = 4'h0;
  localparam logic [3:0] BIT_ONE = 4'h1;
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [3:0] BIT_END = 4'h9;

  // ----------------------------------------------------------------
  // register pointer, power-on contents and read-back fill bits
  // ----------------------------------------------------------------
  localparam logic [7:0] PTR_RST = 8'h80;
  localparam logic [4:0] LEVEL_RST = 5'h17;
  localparam logic [2:0] POLICY_RST = 3'h1;
  localparam logic [2:0] FILL_ONES = 3'h7;
  localparam logic [2:0] FILL_ZEROS = 3'h0;

  // ----------------------------------------------------------------
  // command byte decode
  // ----------------------------------------------------------------
  localparam int CMD_TOP = 7;
  localparam int CMD_NEXT = 6;
  localparam logic [1:0] SEL_REV = 2'h0;
  localparam logic [1:0] SEL_LEVEL = 2'h1;
  localparam logic [1:0] SEL_POLICY = 2'h2;
  localparam logic [1:0] SEL_PART = 2'h3;

  // ----------------------------------------------------------------
  // synchroniser lanes
  // ----------------------------------------------------------------
  localparam int SYNC_W = 4;
  localparam int SY_SCL = 0;
  localparam int SY_SDA = 1;
  localparam int SY_STRAP = 2;
  localparam int SY_TOG = 3;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_ADDR = 6'h02,
    ST_CMD = 6'h04,
    ST_DATA = 6'h08,
    ST_TX = 6'h10,
    ST_SKIP = 6'h20
  } ldsmb_state_e;

endpackage : ldsmb_pkg

// File: rtl/ldsmb_sync.sv
/*
  Two-flop level synchroniser, one lane per bit.
  Assumes inputs are levels from another clock domain or from pins.
*/
`timescale 1ns/100ps
module ldsmb_sync #(
  parameter int WIDTH = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // levels
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_lane
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          meta_q[gi] <= 1'b0;
          sync_out[gi] <= 1'b0;
        end else begin
          meta_q[gi] <= async_in[gi];
          sync_out[gi] <= meta_q[gi];
        end
      end
    end
  endgenerate

endmodule : ldsmb_sync

// File: rtl/ldsmb_regs.sv
/*
  Register file: pointer, lamp level, off policy, read-only flags and ids.
  Assumes commit strobes arrive as one-cycle pulses on sys_clk.
*/
`timescale 1ns/100ps
module ldsmb_regs #(
  parameter logic [7:0] PART_ID = 8'h5c,   // arbitrary value
  parameter logic [7:0] PART_REV = 8'h01,  // arbitrary value
  parameter logic [7:0] MAKER_ID = 8'h3a   // arbitrary value
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // commit from the bus engine
  input wire logic ptr_we,
  input wire logic data_we,
  input wire logic [7:0] cmd_in,
  input wire logic [7:0] data_in,
  // lamp side
  input wire logic [1:0] fault_flags,
  output logic [4:0] lamp_level,
  output logic [2:0] lamp_off_policy,
  // read data for the shifter
  output logic [7:0] rd_data
);

  logic [7:0] ptr_q, ptr_d;
  logic [4:0] level_q, level_d;
  logic [2:0] policy_q, policy_d;
  logic [7:0] rd_q, rd_d;

  always_comb begin
    ptr_d = ptr_q;
    level_d = level_q;
    policy_d = policy_q;
    if (ptr_we) begin
      ptr_d = cmd_in;
    end
    if (data_we) begin
      if (!cmd_in[ldsmb_pkg::CMD_TOP]) begin
        if (cmd_in[1:0] == ldsmb_pkg::SEL_LEVEL) begin
          level_d = data_in[4:0];
        end else if (cmd_in[1:0] == ldsmb_pkg::SEL_POLICY) begin
          policy_d = data_in[2:0];
        end
      end else if (!cmd_in[ldsmb_pkg::CMD_NEXT]) begin
        level_d = data_in[7:3];
      end
      // id selections fall through unchanged
    end
    if (!ptr_q[ldsmb_pkg::CMD_TOP]) begin
      case (ptr_q[1:0])
        ldsmb_pkg::SEL_LEVEL: rd_d = {ldsmb_pkg::FILL_ZEROS, level_q};
        ldsmb_pkg::SEL_POLICY: rd_d = {fault_flags, ldsmb_pkg::FILL_ONES, policy_q};
        ldsmb_pkg::SEL_PART: rd_d = PART_ID;
        default: rd_d = PART_REV;
      endcase
    end else if (!ptr_q[ldsmb_pkg::CMD_NEXT]) begin
      rd_d = {level_q, 1'b1, fault_flags};
    end else begin
      rd_d = ptr_q[0] ? PART_ID : MAKER_ID;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ptr_q <= ldsmb_pkg::PTR_RST;
      level_q <= ldsmb_pkg::LEVEL_RST;
      policy_q <= ldsmb_pkg::POLICY_RST;
      rd_q <= 8'h00;
    end else begin
      ptr_q <= ptr_d;
      level_q <= level_d;
      policy_q <= policy_d;
      rd_q <= rd_d;
    end
  end

  assign lamp_level = level_q;
  assign lamp_off_policy = policy_q;
  assign rd_data = rd_q;

  a_id_write_ignored: assert property (@(posedge sys_clk) disable iff (!resetn)
    (data_we && cmd_in[ldsmb_pkg::CMD_TOP] && cmd_in[ldsmb_pkg::CMD_NEXT]) |=>
    ($stable(level_q) && $stable(policy_q)))
    else $error("id write changed a register");

  a_level_write: assert property (@(posedge sys_clk) disable iff (!resetn)
    (data_we && !cmd_in[ldsmb_pkg::CMD_TOP] && cmd_in[1:0] == ldsmb_pkg::SEL_LEVEL) |=>
    (level_q == $past(data_in[4:0])))
    else $error("level write not stored");

endmodule : ldsmb_regs

// File: verif/ldsmb_host.sv
/*
  Behavioural bus master for the lamp dimmer two-wire slave.
  Assumes an open-drain data line with pull-up resolved by the bench,
  and a free-running link_clk that paces the bus clock.
*/
`timescale 1ns/100ps
module ldsmb_host (
  // pacing
  input wire logic link_clk,
  // bus lines
  input wire logic sda_line,
  output logic scl,
  output logic sda_rel
);
  // clock stands high between frames
  initial begin
    scl = 1'b1;
    sda_rel = 1'b1;
  end

  // ----------------------------------------------------------------
  // bus phases
  // ----------------------------------------------------------------
  task automatic half();
    repeat (16) @(posedge link_clk);
  endtask : half

  // start or repeated start, clock left low
  task automatic start();
    repeat (4) @(posedge link_clk);
    sda_rel = 1'b1;
    half();
    scl = 1'b1;
    half();
    sda_rel = 1'b0;
    half();
    scl = 1'b0;
  endtask : start

  task automatic stop();
    repeat (4) @(posedge link_clk);
    sda_rel = 1'b0;
    half();
    scl = 1'b1;
    half();
    sda_rel = 1'b1;
    half();
  endtask : stop

  // data moved only while clock low, sampled late in high phase
  task automatic bit_io(input logic b, output logic r);
    repeat (4) @(posedge link_clk);
    sda_rel = b;
    half();
    scl = 1'b1;
    half();
    r = sda_line;
    scl = 1'b0;
  endtask : bit_io

  task automatic wr_byte(input logic [7:0] v, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(v[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask : wr_byte

  task automatic rd_byte(input logic nack, output logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, v[i]);
    bit_io(nack, r);
  endtask : rd_byte
endmodule : ldsmb_host

// File: verif/lamp_dimmer_smbus_slave_tb_top.sv
/*
  Self-checking bench of the lamp dimmer two-wire slave.
  Assumes ldsmb_pkg, ldsmb_slave and the ldsmb_host master model.
*/
`timescale 1ns/100ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin failures++; \
  $display("mismatch %s expected %h seen %h", nm, e, g); end end
module lamp_dimmer_smbus_slave_tb_top;
  localparam logic [7:0] PID = 8'h6b; // arbitrary value
  localparam logic [7:0] REV = 8'h02; // arbitrary value
  localparam logic [7:0] MID = 8'h21; // arbitrary value
  localparam logic [7:0] AW = 8'h5a;
  localparam logic [7:0] AR = 8'h5b;
  logic sys_clk, link_clk, resetn, strap, scl, sda_rel, d_out, oen_n;
  logic [1:0] fault_flags;
  logic [4:0] lamp_level;
  logic [2:0] lamp_off_policy;
  wire sda_line = sda_rel & (oen_n | d_out);
  int failures = 0;
  int tests_run = 0;

  ldsmb_slave #(.PART_ID(PID), .PART_REV(REV), .MAKER_ID(MID)) u_ldsmb_slave (
    .sys_clk(sys_clk), .resetn(resetn), .iface_select_strap(strap),
    .shared_clock_pin(scl), .shared_data_in(sda_line), .shared_data_out(d_out),
    .shared_data_oen_n(oen_n), .fault_flags(fault_flags), .lamp_level(lamp_level),
    .lamp_off_policy(lamp_off_policy));
  ldsmb_host u_ldsmb_host (.link_clk(link_clk), .sda_line(sda_line), .scl(scl), .sda_rel(sda_rel));

  initial sys_clk = 1'b0;
  always #25 sys_clk = ~sys_clk;
  initial begin
    link_clk = 1'b0;
    #7;
    forever #16 link_clk = ~link_clk;
  end

  // device may only move the data line while clock is low
  always @(oen_n) if (resetn === 1'b1) `CHK("clock at data change", 1'b0, scl)

  // ----------------------------------------------------------------
  // bus transactions
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, c, d, input int n, input logic ea);
    logic ack;
    u_ldsmb_host.start();
    u_ldsmb_host.wr_byte(a, ack);
    `CHK("addr ack", ea, ack)
    u_ldsmb_host.wr_byte(c, ack);
    `CHK("cmd ack", ea, ack)
    if (n > 1) begin
      u_ldsmb_host.wr_byte(d, ack);
      `CHK("data ack", ea, ack)
    end
    u_ldsmb_host.stop();
  endtask : wr

  task automatic rd(input logic [7:0] c, input logic [7:0] e);
    logic ack;
    logic [7:0] v;
    u_ldsmb_host.start();
    u_ldsmb_host.wr_byte(AW, ack);
    u_ldsmb_host.wr_byte(c, ack);
    u_ldsmb_host.start();
    u_ldsmb_host.wr_byte(AR, ack);
    `CHK("read addr ack", 1'b1, ack)
    u_ldsmb_host.rd_byte(1'b1, v);
    u_ldsmb_host.stop();
    `CHK("read byte", e, v)
  endtask : rd

  task automatic rcv(input logic [7:0] e);
    logic ack;
    logic [7:0] v;
    u_ldsmb_host.start();
    u_ldsmb_host.wr_byte(AR, ack);
    u_ldsmb_host.rd_byte(1'b1, v);
    u_ldsmb_host.stop();
    `CHK("receive byte", e, v)
  endtask : rcv

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_power_up();
    `CHK("level", 5'h17, lamp_level)
    `CHK("policy", 3'h1, lamp_off_policy)
    `CHK("data released", 1'b1, oen_n)
    `CHK("drive level", 1'b0, d_out)
    rcv(8'hbf);
  endtask : t_power_up

  task automatic t_level_write();
    logic ack;
    u_ldsmb_host.start();
    u_ldsmb_host.wr_byte(AW, ack);
    u_ldsmb_host.wr_byte(8'h01, ack);
    u_ldsmb_host.wr_byte(8'h0a, ack);
    `CHK("data ack", 1'b1, ack)
    `CHK("level before stop", 5'h17, lamp_level)
    u_ldsmb_host.stop();
    `CHK("level after stop", 5'h0a, lamp_level)
    rd(8'h01, 8'h0a);
    rd(8'h7d, 8'h0a);
  endtask : t_level_write

  task automatic t_policy();
    @(negedge sys_clk) fault_flags = 2'b01;
    wr(AW, 8'h02, 8'h05, 2, 1'b1);
    `CHK("policy", 3'h5, lamp_off_policy)
    rd(8'h02, 8'h7d);
    @(negedge sys_clk) fault_flags = 2'b11;
  endtask : t_policy

  task automatic t_left_just();
    wr(AW, 8'h80, 8'ha8, 2, 1'b1);
    `CHK("level", 5'h15, lamp_level)
    rcv(8'haf);
    wr(AW, 8'h01, 8'h00, 1, 1'b1);
    rcv(8'h15);
  endtask : t_left_just

  task automatic t_ids();
    logic [7:0] cmd [4] = '{8'h03, 8'h04, 8'hfe, 8'hff};
    logic [7:0] exp [4] = '{PID, REV, MID, PID};
    for (int i = 0; i < 4; i++) rd(cmd[i], exp[i]);
    wr(AW, 8'h03, 8'h00, 2, 1'b1);
    rd(8'h03, PID);
  endtask : t_ids

  task automatic t_abort();
    logic ack;
    logic r;
    u_ldsmb_host.start();
    u_ldsmb_host.wr_byte(AW, ack);
    u_ldsmb_host.wr_byte(8'h01, ack);
    for (int i = 0; i < 4; i++) u_ldsmb_host.bit_io(1'b0, r);
    u_ldsmb_host.stop();
    `CHK("level after abort", 5'h15, lamp_level)
    rcv(PID);
  endtask : t_abort

  task automatic t_foreign();
    wr(8'h5c, 8'h01, 8'h00, 2, 1'b0);
    `CHK("level", 5'h15, lamp_level)
  endtask : t_foreign

  task automatic t_strap();
    @(negedge sys_clk) strap = 1'b0;
    repeat (8) @(negedge sys_clk);
    wr(AW, 8'h01, 8'h00, 2, 1'b0);
    @(negedge sys_clk) strap = 1'b1;
    repeat (8) @(negedge sys_clk);
    `CHK("level", 5'h15, lamp_level)
    rd(8'h01, 8'h15);
  endtask : t_strap

  task automatic complete_run();
    if (failures == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : complete_run

  initial begin
    resetn = 1'b0;
    strap = 1'b1;
    fault_flags = 2'b11;
    repeat (16) @(posedge sys_clk);
    @(negedge sys_clk) resetn = 1'b1;
    repeat (8) @(negedge sys_clk);
    t_power_up();
    t_level_write();
    t_policy();
    t_left_just();
    t_ids();
    t_abort();
    t_foreign();
    t_strap();
    complete_run();
  end

  // hang guard, far beyond the expected run
  initial begin
    #2000000;
    failures++;
    complete_run();
  end
endmodule : lamp_dimmer_smbus_slave_tb_top
